// ===== expander_pkg.sv
// shared constants of the peripheral interrupt expander
package expander_pkg;

	// group and line geometry
	localparam int GROUPS = 12;
	localparam int LINES = 8;
	localparam int TOTAL_LINES = GROUPS * LINES;

	// widths of the configuration, vector table, acceptance and trap ports
	localparam int CFG_ADDR_W = 8;
	localparam int VEC_IDX_W = 7;
	localparam int TRAP_NUM_W = 4;
	localparam int GROUP_IDX_W = 4;
	localparam int LINE_IDX_W = 3;

	// configuration word index of the first group enable register;
	// enable and flag registers of each group follow as pairs
	localparam logic [CFG_ADDR_W-1:0] CFG_GROUP_BASE = 8'h02;
	localparam logic [CFG_ADDR_W-1:0] CFG_GROUP_STRIDE = 8'h02;

	// reset values of the group registers
	localparam logic [LINES-1:0] ENABLE_RESET = 8'h00;
	localparam logic [LINES-1:0] FLAG_RESET = 8'h00;

	// remap select bit position and reset value
	localparam int REMAP_SELECT_BIT = 0;
	localparam logic REMAP_RESET = 1'b0;

	// group that carries the six capture units
	localparam int CAPTURE_GROUP = 4;
	localparam int CAPTURE_UNITS = 6;

	// lines wired to peripherals, bit 0 is line 1 of group 1
	localparam logic [TOTAL_LINES-1:0] WIRED_LINES = {
		8'hdf, 8'h00, 8'h00, 8'hff, 8'h33, 8'h3f,
		8'h3f, 8'h03, 8'h3f, 8'h3f, 8'h3f, 8'hfb};

	// software vector request number that would mean the reset vector
	localparam logic [TRAP_NUM_W-1:0] TRAP_RESET_NUM = 4'h0;

endpackage

// ===== interrupt_group.sv
// one group of eight lines: enable register, flag register, group request
`timescale 1ns/1ps
module interrupt_group #(
	parameter int LINES = 8,
	parameter logic [LINES-1:0] WIRED = 8'hff
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [LINES-1:0] line_irq, // peripheral requests
	input wire logic enable_wr, // write of the group enable register
	input wire logic flag_wr, // write of the group flag register
	input wire logic [LINES-1:0] wdata,
	input wire logic [LINES-1:0] ack_clr, // flag clears on acceptance
	output logic [LINES-1:0] enable_q,
	output logic [LINES-1:0] flag_q,
	output logic group_irq
);

	logic [LINES-1:0] enable_reg, enable_next;
	logic [LINES-1:0] flag_reg, flag_next;
	logic irq_reg, irq_next;
	logic [LINES-1:0] hw_set; // peripheral sets from wired lines only

	////////////////////////////////////////////////////////////////////////
	// next values of enable, flag and group request
	always_comb begin
		// reserved lines ignore their input, so only software sets them
		hw_set = line_irq & WIRED;
		enable_next = enable_reg;
		if (enable_wr) begin
			enable_next = wdata;
		end
		flag_next = flag_reg;
		if (flag_wr) begin
			// a software write replaces the whole flag word; a pending
			// peripheral flag written as zero is lost unless it sets
			// again in the same cycle
			flag_next = wdata;
		end else begin
			flag_next = flag_reg & ~ack_clr;
		end
		// a set arriving with a clear wins
		flag_next = flag_next | hw_set;
		// request while any line is both flagged and enabled
		irq_next = |(flag_next & enable_next);
	end

	////////////////////////////////////////////////////////////////////////
	// registers, frozen while ce is low
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			enable_reg <= expander_pkg::ENABLE_RESET;
			flag_reg <= expander_pkg::FLAG_RESET;
			irq_reg <= 1'b0;
		end else if (ce) begin
			enable_reg <= enable_next;
			flag_reg <= flag_next;
			irq_reg <= irq_next;
		end
	end

	assign enable_q = enable_reg;
	assign flag_q = flag_reg;
	assign group_irq = irq_reg;

endmodule

// ===== peripheral_interrupt_expander.sv
// peripheral interrupt expander: twelve groups of eight lines to the cpu
`timescale 1ns/1ps
module peripheral_interrupt_expander #(
	parameter int VEC_W = 22 // width of a stored vector address
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce, // clock enable, freezes all state when low
	// peripheral requests, bit 0 is line 1 of group 1
	input wire logic [expander_pkg::TOTAL_LINES-1:0] periph_irq,
	// capture unit requests one to six
	input wire logic [expander_pkg::CAPTURE_UNITS-1:0] capture_unit_irq,
	input wire logic expander_enable, // expander in use by the cpu
	input wire logic write_unlock_state, // protected writes allowed
	// configuration register writes
	input wire logic cfg_wr,
	input wire logic [expander_pkg::CFG_ADDR_W-1:0] cfg_addr,
	input wire logic [expander_pkg::LINES-1:0] cfg_wdata,
	// vector table writes
	input wire logic vec_wr,
	input wire logic [expander_pkg::VEC_IDX_W-1:0] vec_idx,
	input wire logic [VEC_W-1:0] vec_wdata,
	// remap register write
	input wire logic remap_wr,
	input wire logic [expander_pkg::LINES-1:0] remap_wdata,
	// cpu acceptance of one line, clears its flag
	input wire logic irq_ack,
	input wire logic [expander_pkg::GROUP_IDX_W-1:0] ack_group,
	input wire logic [expander_pkg::LINE_IDX_W-1:0] ack_line,
	// software vector request
	input wire logic trap_req,
	input wire logic [expander_pkg::TRAP_NUM_W-1:0] trap_num,
	output logic trap_valid,
	output logic trap_undefined,
	output logic [VEC_W-1:0] trap_vector,
	// cpu interrupt lines, bit 0 is group 1
	output logic [expander_pkg::GROUPS-1:0] cpu_irq,
	// register contents for software reads
	output logic [expander_pkg::TOTAL_LINES-1:0] enable_bits,
	output logic [expander_pkg::TOTAL_LINES-1:0] flag_bits,
	output logic pwm_in_dma_frame
);

	localparam int G = expander_pkg::GROUPS;
	localparam int L = expander_pkg::LINES;
	localparam int NV = expander_pkg::TOTAL_LINES;

	// vector table: one entry per line only, no reset entry; a request
	// for number zero therefore has nothing to fetch and is refused
	// with the undefined flag set while the previous address stays on trap_vector
	logic [VEC_W-1:0] vec_mem [0:NV-1];
	logic [NV-1:0] line_src; // line inputs after source routing
	logic [G-1:0] enable_wr, flag_wr;
	logic [NV-1:0] ack_clr;

	// returns the vector index of line 1 of a group numbered from one
	// callers pass only 1..12, so the wrap of zero is never used
	function automatic logic [expander_pkg::VEC_IDX_W-1:0] first_line_of_group(
		input logic [expander_pkg::TRAP_NUM_W-1:0] num);
		logic [expander_pkg::VEC_IDX_W-1:0] g;
		g = {3'h0, num} - 7'h01;
		return g << 3;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// source routing
	always_comb begin
		line_src = periph_irq;
		// capture units own lines 1..6 of their group; lines 7 and 8
		// stay reserved and are masked in the group by its wired mask
		// the general bits of lines 1..6 are overwritten, so a stray
		// level there can never pose as a capture request
		for (int i = 0; i < expander_pkg::CAPTURE_UNITS; i++) begin
			line_src[(expander_pkg::CAPTURE_GROUP - 1) * L + i] =
				capture_unit_irq[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration decode: enable and flag pairs at consecutive words
	always_comb begin
		enable_wr = '0;
		flag_wr = '0;
		// these writes take no unlock, unlike the vector table
		// unmapped word indices match no group and change nothing
		for (int g = 0; g < G; g++) begin
			if (cfg_wr && cfg_addr == expander_pkg::CFG_GROUP_BASE +
				8'(g) * expander_pkg::CFG_GROUP_STRIDE) begin
				enable_wr[g] = 1'b1;
			end
			if (cfg_wr && cfg_addr == expander_pkg::CFG_GROUP_BASE +
				8'(g) * expander_pkg::CFG_GROUP_STRIDE + 8'h01) begin
				flag_wr[g] = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// acceptance decode, one flag bit per acknowledge
	always_comb begin
		ack_clr = '0;
		// group numbers outside 1..12 clear nothing
		// acknowledging an idle line is harmless, its flag is clear
		if (irq_ack && ack_group != 4'h0 && ack_group <= 4'(G)) begin
			ack_clr[({3'h0, ack_group} - 7'h01) * 7'(L) +
				{4'h0, ack_line}] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// twelve groups, each driving one cpu line
	for (genvar g = 0; g < G; g++) begin : grp
		interrupt_group #(
			.LINES(L),
			.WIRED(expander_pkg::WIRED_LINES[g*L +: L])
		) u_group (
			.clk_sys(clk_sys),
			.rstn(rstn),
			.ce(ce),
			.line_irq(line_src[g*L +: L]),
			.enable_wr(enable_wr[g]),
			.flag_wr(flag_wr[g]),
			.wdata(cfg_wdata),
			.ack_clr(ack_clr[g*L +: L]),
			.enable_q(enable_bits[g*L +: L]),
			.flag_q(flag_bits[g*L +: L]),
			.group_irq(cpu_irq[g])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// vector table writes, honoured only under the unlock state
	always_ff @(posedge clk_sys) begin
		// no reset on the table: its contents are data, not control
		if (ce && vec_wr && write_unlock_state && vec_idx < 7'(NV)) begin
			vec_mem[vec_idx] <= vec_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software vector request
	logic trap_valid_reg, trap_valid_next;
	logic trap_undef_reg, trap_undef_next;
	logic [VEC_W-1:0] trap_vec_reg, trap_vec_next;

	// decode of the request number, answered one edge later
	always_comb begin
		trap_valid_next = 1'b0;
		trap_undef_next = 1'b0;
		trap_vec_next = trap_vec_reg;
		// while disabled the expander does not answer; the cpu then
		// takes its vector elsewhere
		if (trap_req && expander_enable) begin
			trap_valid_next = 1'b1;
			if (trap_num == expander_pkg::TRAP_RESET_NUM ||
				trap_num > 4'(G)) begin
				// no entry exists: flag it and keep the old vector
				trap_undef_next = 1'b1;
			end else begin
				trap_vec_next = vec_mem[first_line_of_group(trap_num)];
			end
		end
	end

	// answer registers: valid and undefined stand for one cycle only
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			trap_valid_reg <= 1'b0;
			trap_undef_reg <= 1'b0;
			trap_vec_reg <= '0;
		end else if (ce) begin
			trap_valid_reg <= trap_valid_next;
			trap_undef_reg <= trap_undef_next;
			trap_vec_reg <= trap_vec_next;
		end
	end

	assign trap_valid = trap_valid_reg;
	assign trap_undefined = trap_undef_reg;
	assign trap_vector = trap_vec_reg;

	////////////////////////////////////////////////////////////////////////
	// pwm remap select, a protected register
	logic pwm_remap_select_bit_reg, pwm_remap_select_bit_next;

	// next remap select, taken only while writes are unlocked
	always_comb begin
		pwm_remap_select_bit_next = pwm_remap_select_bit_reg;
		// one moves the pwm registers to the dma frame, zero keeps them
		// in the ordinary 32-bit frame
		if (remap_wr && write_unlock_state) begin
			pwm_remap_select_bit_next =
				remap_wdata[expander_pkg::REMAP_SELECT_BIT];
		end
	end

	// remap register, cleared by reset so pwm starts in its usual frame
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pwm_remap_select_bit_reg <= expander_pkg::REMAP_RESET;
		end else if (ce) begin
			pwm_remap_select_bit_reg <= pwm_remap_select_bit_next;
		end
	end

	assign pwm_in_dma_frame = pwm_remap_select_bit_reg;

endmodule

// ===== irq_source.sv
// peripheral request source model facing the expander inputs
`timescale 1ns/1ps
module irq_source (
	input wire logic [6:0] sel, // line to raise as a level, 7'h7f for none
	input wire logic [2:0] cap, // capture unit to raise, 0 for none
	output logic [expander_pkg::TOTAL_LINES-1:0] periph_irq,
	output logic [expander_pkg::CAPTURE_UNITS-1:0] capture_unit_irq
);
	// levels follow the bench selects, which move only on falling edges
	assign periph_irq = (sel == 7'h7f) ? '0 : 96'h1 << sel;
	assign capture_unit_irq = (cap == 3'h0) ? '0 : 6'h1 << (cap - 3'h1);
endmodule

// ===== expander_assertions.sv
// concurrent checks on the expander ports
`timescale 1ns/1ps
module expander_assertions (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [5:0] capture_unit_irq,
	input wire logic cfg_wr,
	input wire logic irq_ack,
	input wire logic remap_wr,
	input wire logic [7:0] remap_wdata,
	input wire logic write_unlock_state,
	input wire logic expander_enable,
	input wire logic trap_req,
	input wire logic [3:0] trap_num,
	input wire logic trap_valid,
	input wire logic trap_undefined,
	input wire logic pwm_in_dma_frame,
	input wire logic [11:0] cpu_irq,
	input wire logic [95:0] enable_bits,
	input wire logic [95:0] flag_bits
);
	logic [11:0] want_irq; // cpu lines implied by visible words
	logic take; // trap request that must be answered
	logic remap_bit;
	assign take = ce && trap_req && expander_enable;
	assign remap_bit = remap_wdata[0];
	// or of flag anded with enable per group, bit 0 is group 1
	always_comb begin
		for (int g = 0; g < 12; g++) begin
			want_irq[g] = |(flag_bits[g*8+:8] & enable_bits[g*8+:8]);
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_group_line: assert property (cpu_irq == want_irq)
		else $error("cpu line differs from flag and enable");
	a_trap_answer: assert property (take |=> trap_valid)
		else $error("trap not answered");
	a_trap_silent: assert property (!take && ce |=> !trap_valid)
		else $error("trap answer without request");
	a_trap_zero: assert property (take &&
		(trap_num == 4'h0 || trap_num > 4'hc) |=> trap_undefined)
		else $error("trap without entry not undefined");
	a_trap_good: assert property (take &&
		trap_num inside {[4'h1:4'hc]} |=> !trap_undefined)
		else $error("trap in range marked undefined");
	a_reserved_quiet: assert property (!cfg_wr |=>
		(flag_bits & ~$past(flag_bits) & ~expander_pkg::WIRED_LINES) == '0)
		else $error("reserved flag set by hardware");
	a_flag_sticky: assert property (!cfg_wr && !irq_ack |=>
		(~flag_bits & $past(flag_bits)) == '0)
		else $error("flag dropped without write or ack");
	a_capture_set: assert property (ce && capture_unit_irq != '0 |=>
		(flag_bits[29:24] & $past(capture_unit_irq)) ==
		$past(capture_unit_irq))
		else $error("capture unit flag not set");
	a_remap_locked: assert property (remap_wr &&
		!write_unlock_state |=> $stable(pwm_in_dma_frame))
		else $error("remap written while locked");
	a_remap_set: assert property (ce && remap_wr &&
		write_unlock_state |=> pwm_in_dma_frame == $past(remap_bit))
		else $error("remap bit not taken");
endmodule
bind peripheral_interrupt_expander expander_assertions chk (
	.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .cfg_wr(cfg_wr),
	.capture_unit_irq(capture_unit_irq), .irq_ack(irq_ack),
	.remap_wr(remap_wr), .remap_wdata(remap_wdata), .trap_num(trap_num),
	.write_unlock_state(write_unlock_state), .trap_req(trap_req),
	.expander_enable(expander_enable), .trap_valid(trap_valid),
	.trap_undefined(trap_undefined), .pwm_in_dma_frame(pwm_in_dma_frame),
	.cpu_irq(cpu_irq), .enable_bits(enable_bits), .flag_bits(flag_bits));

// ===== tb_top.sv
// self-checking bench for the peripheral interrupt expander
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
	logic clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, expander_enable = 1'b1;
	logic write_unlock_state = 1'b0, cfg_wr = 1'b0, vec_wr = 1'b0;
	logic remap_wr = 1'b0, irq_ack = 1'b0, trap_req = 1'b0;
	logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, remap_wdata = 8'h00;
	logic [6:0] vec_idx = 7'h00, sel = 7'h7f;
	logic [21:0] vec_wdata = 22'h000000, trap_vector;
	logic [3:0] ack_group = 4'h0, trap_num = 4'h0;
	logic [2:0] ack_line = 3'h0, cap = 3'h0;
	logic trap_valid, trap_undefined, pwm_in_dma_frame;
	logic [11:0] cpu_irq;
	logic [95:0] enable_bits, flag_bits, periph_irq;
	logic [5:0] capture_unit_irq;
	int failures = 0;
	int n_compared = 0;
	always #20 clk_sys = ~clk_sys;
	irq_source src (.sel(sel), .cap(cap), .periph_irq(periph_irq),
		.capture_unit_irq(capture_unit_irq));
	peripheral_interrupt_expander uut (.clk_sys(clk_sys), .rstn(rstn),
		.ce(ce), .periph_irq(periph_irq), .capture_unit_irq(capture_unit_irq),
		.expander_enable(expander_enable), .write_unlock_state(write_unlock_state),
		.cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.vec_wr(vec_wr), .vec_idx(vec_idx), .vec_wdata(vec_wdata),
		.remap_wr(remap_wr), .remap_wdata(remap_wdata), .irq_ack(irq_ack),
		.ack_group(ack_group), .ack_line(ack_line), .trap_req(trap_req),
		.trap_num(trap_num), .trap_valid(trap_valid), .trap_vector(trap_vector),
		.trap_undefined(trap_undefined), .cpu_irq(cpu_irq),
		.enable_bits(enable_bits), .flag_bits(flag_bits),
		.pwm_in_dma_frame(pwm_in_dma_frame));
	////////////////////////////////////////////////////////////////////////
	// one group register write strobe, held over one rising edge
	task automatic cfg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_wdata = d;
		@(negedge clk_sys);
		cfg_wr = 1'b0;
	endtask
	// trap request; the answer stands one cycle, so it is read right away
	task automatic trap(input logic [3:0] n, input logic v, input logic u);
		@(negedge clk_sys);
		trap_req = 1'b1;
		trap_num = n;
		@(negedge clk_sys);
		trap_req = 1'b0;
		`CHK("trap valid", v, trap_valid)
		if (v) `CHK("trap undefined", u, trap_undefined)
	endtask
	// remap write with a chosen unlock state
	task automatic remap(input logic u, input logic d);
		@(negedge clk_sys);
		remap_wr = 1'b1;
		write_unlock_state = u;
		remap_wdata = {7'h00, d};
		@(negedge clk_sys);
		remap_wr = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	// software flag on line 8 of every group, word 1a past group 12 is unmapped and safe
	task automatic t_groups;
		for (int g = 0; g < 12; g++) begin
			cfg(8'h02 + 8'(2 * g), 8'h80);
			cfg(8'h03 + 8'(2 * g), 8'h80);
			`CHK("group flags", 8'h80, flag_bits[g*8+:8])
			`CHK("cpu line", 1'b1, cpu_irq[g])
		end
		`CHK("all lines", 12'hfff, cpu_irq)
		cfg(8'h1a, 8'hff);
		`CHK("unmapped", {12{8'h80}}, enable_bits)
		for (int g = 0; g < 12; g++) begin
			cfg(8'h02 + 8'(2 * g), 8'h00);
			`CHK("masked line", 1'b0, cpu_irq[g])
			cfg(8'h03 + 8'(2 * g), 8'h00);
		end
	endtask
	// peripheral levels, reserved lines, capture units and acceptance
	task automatic t_periph;
		cfg(8'h02, 8'h01);
		cfg(8'h08, 8'h3f);
		sel = 7'd2;
		@(negedge clk_sys);
		sel = 7'd24;
		@(negedge clk_sys);
		`CHK("reserved", 1'b0, flag_bits[2])
		sel = 7'd0;
		cap = 3'h3;
		@(negedge clk_sys);
		sel = 7'h7f;
		cap = 3'h0;
		`CHK("group 4 flags", 8'h04, flag_bits[31:24])
		`CHK("line one", 12'h009, cpu_irq)
		irq_ack = 1'b1;
		ack_group = 4'h4;
		ack_line = 3'h2;
		@(negedge clk_sys);
		irq_ack = 1'b0;
		`CHK("acked", 12'h001, cpu_irq)
		cfg(8'h03, 8'h00);
		`CHK("lost flag", 1'b0, flag_bits[0])
	endtask
	// vector table under unlock, traps one to thirteen, then disabled;
	// number zero is only ever requested while the expander is off
	task automatic t_trap;
		write_unlock_state = 1'b1;
		for (int n = 1; n <= 12; n++) begin
			@(negedge clk_sys);
			vec_wr = 1'b1;
			vec_idx = 7'((n - 1) * 8);
			vec_wdata = 22'h3a0000 + 22'(n);
		end
		@(negedge clk_sys);
		write_unlock_state = 1'b0;
		vec_idx = 7'h00;
		vec_wdata = 22'h000bad;
		@(negedge clk_sys);
		vec_wr = 1'b0;
		for (int n = 1; n <= 12; n++) begin
			trap(4'(n), 1'b1, 1'b0);
			`CHK("vector", 22'h3a0000 + 22'(n), trap_vector)
		end
		trap(4'hd, 1'b1, 1'b1);
		`CHK("kept vector", 22'h3a000c, trap_vector)
		expander_enable = 1'b0;
		trap(4'h0, 1'b0, 1'b0);
		trap(4'h1, 1'b0, 1'b0);
		expander_enable = 1'b1;
	endtask
	// remap bit: locked write refused, frozen clock ignored
	task automatic t_remap;
		remap(1'b0, 1'b1);
		`CHK("locked remap", 1'b0, pwm_in_dma_frame)
		remap(1'b1, 1'b1);
		`CHK("remap on", 1'b1, pwm_in_dma_frame)
		ce = 1'b0;
		remap(1'b1, 1'b0);
		`CHK("frozen", 1'b1, pwm_in_dma_frame)
		ce = 1'b1;
		remap(1'b1, 1'b0);
		`CHK("remap off", 1'b0, pwm_in_dma_frame)
	endtask
	// mid-run reset clears all but the table; first write right after
	task automatic t_reset;
		remap(1'b1, 1'b1);
		cfg(8'h04, 8'h01);
		cfg(8'h05, 8'h01);
		`CHK("set line", 12'h002, cpu_irq)
		rstn = 1'b0;
		@(negedge clk_sys);
		`CHK("reset remap", 1'b0, pwm_in_dma_frame)
		`CHK("reset enables", 96'h0, enable_bits)
		`CHK("reset flags", 96'h0, flag_bits)
		`CHK("reset lines", 12'h000, cpu_irq)
		`CHK("reset vector", 22'h000000, trap_vector)
		rstn = 1'b1;
		cfg(8'h02, 8'h01);
		`CHK("first write", 96'h1, enable_bits)
		trap(4'h2, 1'b1, 1'b0);
		`CHK("table kept", 22'h3a0002, trap_vector)
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// watchdog: the tests need well under a thousand cycles
	initial begin
		#80000;
		failures++;
		tally_and_finish;
	end
	initial begin
		repeat (6) @(negedge clk_sys);
		rstn = 1'b1;
		`CHK("reset flags", 96'h0, flag_bits)
		t_groups;
		t_periph;
		t_trap;
		t_remap;
		t_reset;
		tally_and_finish;
	end
endmodule
